// File: logic/thermal_limit_map.svh
/*
 * Register offsets, field positions, reset values of the thermal limit bank.
 * Assumes an 8-bit register address from the serial target front end.
 */
`ifndef THERMAL_LIMIT_MAP_SVH
`define THERMAL_LIMIT_MAP_SVH

`define TL_ADDR_W               8
`define TL_ADDR_LOWER_LSB       8'h1e
`define TL_ADDR_LOWER_MSB       8'h1f
`define TL_ADDR_CRIT_UPPER_LSB  8'h20
`define TL_ADDR_CRIT_UPPER_MSB  8'h21
`define TL_ADDR_CRIT_LOWER_LSB  8'h22
`define TL_ADDR_CRIT_LOWER_MSB  8'h23
`define TL_ADDR_DEV_STATUS      8'h30

`define TL_RST_LOWER_LSB        8'h00
`define TL_RST_LOWER_MSB        8'h00
`define TL_RST_CRIT_UPPER_LSB   8'h50
`define TL_RST_CRIT_UPPER_MSB   8'h05
`define TL_RST_CRIT_LOWER_LSB   8'h00
`define TL_RST_CRIT_LOWER_MSB   8'h00
`define TL_RST_DEV_STATUS       8'h00

`define TL_PENDING_BIT          7
`define TL_UNMAPPED_READ        8'h00

`endif

// File: logic/thermal_limit_pkg.sv
/*
 * Types shared by the thermal limit bank and its comparator.
 * Assumes thresholds and readings are 16-bit two's complement values.
 */
package thermal_limit_pkg;
    typedef logic signed [15:0] temp_t;
    typedef logic [7:0]         byte_t;
    typedef enum logic [2:0] {
        sel_none       = 3'h0,
        sel_lower_lsb  = 3'h1,
        sel_lower_msb  = 3'h3,
        sel_cupper_lsb = 3'h2,
        sel_cupper_msb = 3'h6,
        sel_clower_lsb = 3'h7,
        sel_clower_msb = 3'h5,
        sel_status     = 3'h4
    } reg_sel_t;
endpackage

// File: logic/limit_cmp_if.sv
/*
 * Carrier between the register bank and its threshold comparator.
 * Assumes both ends sit in the sys_clk domain.
 */
`timescale 1ns/10ps
interface limit_cmp_if;
    thermal_limit_pkg::temp_t reading;
    thermal_limit_pkg::temp_t lower;
    thermal_limit_pkg::temp_t crit_lower;
    logic                     below_lower;
    logic                     above_lower;
    logic                     below_crit_lower;
    logic                     above_crit_lower;

    modport bank (
        output reading, lower, crit_lower,
        input  below_lower, above_lower, below_crit_lower, above_crit_lower
    );
    modport cmp (
        input  reading, lower, crit_lower,
        output below_lower, above_lower, below_crit_lower, above_crit_lower
    );
endinterface

// File: logic/limit_compare.sv
/*
 * Signed threshold comparator for the low and critical-low limits.
 * Assumes inputs are stable registered values; output is combinational.
 */
`timescale 1ns/10ps
module limit_compare (
    limit_cmp_if.cmp c
);
    // Equal to the limit is neither below nor above, so a flag holds there
    assign c.below_lower      = c.reading < c.lower;
    assign c.above_lower      = c.reading > c.lower;
    assign c.below_crit_lower = c.reading < c.crit_lower;
    assign c.above_crit_lower = c.reading > c.crit_lower;
endmodule

// File: logic/thermal_limit_register_bank.sv
/*
 * Thermal limit register bank: low, critical-high and critical-low limits,
 * device status with the pending interrupt flag, and the low-side flags.
 * Assumes a byte register port driven by the serial target front end,
 * a sensed reading with a one-cycle valid strobe, and interrupt events
 * from the neighbouring interrupt logic, all synchronous to sys_clk.
 */
// Summary of operation
// - Two low-limit bytes form the 16-bit lower threshold; both reset to zero.
// - Two bytes form the critical upper threshold; reset 0x50 low, 0x05 high.
// - Two zero-reset bytes form the 16-bit critical lower threshold.
// - Reserved bits are read-only, written as zero, read back as zero.
// - Status bit 7 shows a pending interrupt; bits 6:0 read zero.
// - Low flag sets when reading is below lower limit, clears when above.
// - Critical low flag sets below critical lower limit, clears when above.
// - Global clear drops pending interrupt and temperature flags.
`timescale 1ns/10ps
`include "thermal_limit_map.svh"
module thermal_limit_register_bank (
    // Clock, reset, enable
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic                     ce,
    // Register port
    input  wire logic [`TL_ADDR_W-1:0]    reg_addr,
    input  wire logic                     reg_wr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_rd,
    output logic      [7:0]               reg_rdata_q,
    // Temperature reading
    input  wire thermal_limit_pkg::temp_t sense_temp,
    input  wire logic                     sense_valid,
    // Interrupt events
    input  wire logic                     ibi_raise,
    input  wire logic                     ibi_done,
    input  wire logic                     clear_all_events,
    // Status and thresholds
    output logic                          pending_interrupt_flag,
    output logic                          below_lower_flag,
    output logic                          below_critical_lower_flag,
    output thermal_limit_pkg::temp_t      lower_threshold_q,
    output thermal_limit_pkg::temp_t      critical_upper_threshold_q,
    output thermal_limit_pkg::temp_t      critical_lower_threshold_q
);
    limit_cmp_if              cmp_bus ();
    thermal_limit_pkg::temp_t reading_q;
    thermal_limit_pkg::reg_sel_t wr_sel;
    thermal_limit_pkg::reg_sel_t rd_sel;
    // Reset byte kept whole so the pending bit is picked out at its position
    localparam thermal_limit_pkg::byte_t status_rst = `TL_RST_DEV_STATUS;

    function automatic thermal_limit_pkg::reg_sel_t decode(input logic [`TL_ADDR_W-1:0] a);
        case (a)
            `TL_ADDR_LOWER_LSB:      decode = thermal_limit_pkg::sel_lower_lsb;
            `TL_ADDR_LOWER_MSB:      decode = thermal_limit_pkg::sel_lower_msb;
            `TL_ADDR_CRIT_UPPER_LSB: decode = thermal_limit_pkg::sel_cupper_lsb;
            `TL_ADDR_CRIT_UPPER_MSB: decode = thermal_limit_pkg::sel_cupper_msb;
            `TL_ADDR_CRIT_LOWER_LSB: decode = thermal_limit_pkg::sel_clower_lsb;
            `TL_ADDR_CRIT_LOWER_MSB: decode = thermal_limit_pkg::sel_clower_msb;
            `TL_ADDR_DEV_STATUS:     decode = thermal_limit_pkg::sel_status;
            default:                 decode = thermal_limit_pkg::sel_none;
        endcase
    endfunction

    assign wr_sel = reg_wr ? decode(reg_addr) : thermal_limit_pkg::sel_none;
    assign rd_sel = decode(reg_addr);

    assign cmp_bus.reading    = reading_q;
    assign cmp_bus.lower      = lower_threshold_q;
    assign cmp_bus.crit_lower = critical_lower_threshold_q;

    limit_compare u_cmp (
        .c (cmp_bus)
    );

    // Limit bytes; full bytes, so no reserved bits to mask on write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lower_threshold_q          <= {`TL_RST_LOWER_MSB, `TL_RST_LOWER_LSB};
            critical_upper_threshold_q <= {`TL_RST_CRIT_UPPER_MSB,
                                           `TL_RST_CRIT_UPPER_LSB};
            critical_lower_threshold_q <= {`TL_RST_CRIT_LOWER_MSB,
                                           `TL_RST_CRIT_LOWER_LSB};
        end else if (ce) begin
            case (wr_sel)
                thermal_limit_pkg::sel_lower_lsb:  lower_threshold_q[7:0]  <= reg_wdata;
                thermal_limit_pkg::sel_lower_msb:  lower_threshold_q[15:8] <= reg_wdata;
                thermal_limit_pkg::sel_cupper_lsb: begin
                    critical_upper_threshold_q[7:0] <= reg_wdata;
                end
                thermal_limit_pkg::sel_cupper_msb: begin
                    critical_upper_threshold_q[15:8] <= reg_wdata;
                end
                thermal_limit_pkg::sel_clower_lsb: begin
                    critical_lower_threshold_q[7:0] <= reg_wdata;
                end
                thermal_limit_pkg::sel_clower_msb: begin
                    critical_lower_threshold_q[15:8] <= reg_wdata;
                end
                // Status is read-only; writes there and elsewhere are dropped
                default: ;
            endcase
        end
    end

    // Readback; reserved status bits come back as zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata_q <= `TL_UNMAPPED_READ;
        end else if (ce && reg_rd) begin
            case (rd_sel)
                thermal_limit_pkg::sel_lower_lsb:  reg_rdata_q <= lower_threshold_q[7:0];
                thermal_limit_pkg::sel_lower_msb:  reg_rdata_q <= lower_threshold_q[15:8];
                thermal_limit_pkg::sel_cupper_lsb: reg_rdata_q <= critical_upper_threshold_q[7:0];
                thermal_limit_pkg::sel_cupper_msb: reg_rdata_q <= critical_upper_threshold_q[15:8];
                thermal_limit_pkg::sel_clower_lsb: reg_rdata_q <= critical_lower_threshold_q[7:0];
                thermal_limit_pkg::sel_clower_msb: reg_rdata_q <= critical_lower_threshold_q[15:8];
                thermal_limit_pkg::sel_status: begin
                    reg_rdata_q <= {pending_interrupt_flag, 7'h00};
                end
                default: reg_rdata_q <= `TL_UNMAPPED_READ;
            endcase
        end
    end

    // Reading is held so flags compare against a stable sample
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reading_q <= 16'sh0000;
        end else if (ce && sense_valid) begin
            reading_q <= sense_temp;
        end
    end

    // Compare one cycle after the sample lands in reading_q
    logic eval_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            eval_q <= 1'b0;
        end else if (ce) begin
            eval_q <= sense_valid;
        end
    end

    // A fresh below or above result wins over a global clear in the same cycle; at equality the clear wins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            below_lower_flag <= 1'b0;
        end else if (ce) begin
            if (eval_q && cmp_bus.below_lower) begin
                below_lower_flag <= 1'b1;
            end else if (eval_q && cmp_bus.above_lower) begin
                below_lower_flag <= 1'b0;
            end else if (clear_all_events) begin
                below_lower_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            below_critical_lower_flag <= 1'b0;
        end else if (ce) begin
            if (eval_q && cmp_bus.below_crit_lower) begin
                below_critical_lower_flag <= 1'b1;
            end else if (eval_q && cmp_bus.above_crit_lower) begin
                below_critical_lower_flag <= 1'b0;
            end else if (clear_all_events) begin
                below_critical_lower_flag <= 1'b0;
            end
        end
    end

    // Pending interrupt; a new event beats a clear arriving with it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pending_interrupt_flag <= status_rst[`TL_PENDING_BIT];
        end else if (ce) begin
            if (ibi_raise) begin
                pending_interrupt_flag <= 1'b1;
            end else if (clear_all_events || ibi_done) begin
                pending_interrupt_flag <= 1'b0;
            end
        end
    end

    property p_lower_write;
        @(posedge sys_clk) disable iff (rst)
        (ce && reg_wr && reg_addr == `TL_ADDR_LOWER_MSB)
            |=> lower_threshold_q[15:8] == $past(reg_wdata);
    endproperty
    a_lower_write: assert property (p_lower_write) else $error("lower msb not stored");

    property p_cupper_reset;
        @(posedge sys_clk)
        rst |=> critical_upper_threshold_q == 16'sh0550;
    endproperty
    a_cupper_reset: assert property (p_cupper_reset) else $error("crit upper reset wrong");

    property p_clower_write;
        @(posedge sys_clk) disable iff (rst)
        (ce && reg_wr && reg_addr == `TL_ADDR_CRIT_LOWER_LSB)
            |=> critical_lower_threshold_q[7:0] == $past(reg_wdata)
                && $stable(critical_lower_threshold_q[15:8]);
    endproperty
    a_clower_write: assert property (p_clower_write) else $error("crit lower lsb wrong");

    property p_reserved_zero;
        @(posedge sys_clk) disable iff (rst)
        (ce && reg_rd && reg_addr == `TL_ADDR_DEV_STATUS) |=> reg_rdata_q[6:0] == 7'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

    property p_status_read;
        @(posedge sys_clk) disable iff (rst)
        (ce && reg_rd && reg_addr == `TL_ADDR_DEV_STATUS)
            |=> reg_rdata_q[7] == $past(pending_interrupt_flag);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status bit 7 wrong");

    property p_low_flag;
        @(posedge sys_clk) disable iff (rst)
        (ce && sense_valid && sense_temp < lower_threshold_q && !(reg_wr))
            ##1 ce |=> below_lower_flag;
    endproperty
    a_low_flag: assert property (p_low_flag) else $error("low flag not set");

    property p_crit_low_clear;
        @(posedge sys_clk) disable iff (rst)
        (ce && sense_valid && sense_temp > critical_lower_threshold_q && !(reg_wr))
            ##1 ce |=> !below_critical_lower_flag;
    endproperty
    a_crit_low_clear: assert property (p_crit_low_clear) else $error("crit low flag stuck");

    property p_global_clear;
        @(posedge sys_clk) disable iff (rst)
        (ce && clear_all_events && !ibi_raise) |=> !pending_interrupt_flag;
    endproperty
    a_global_clear: assert property (p_global_clear) else $error("pending not cleared");
endmodule

// File: bench/reg_host.sv
/*
 * Host model for the register port of the thermal limit bank.
 * Assumes the bank samples requests on the rising edge of sys_clk.
 */
`timescale 1ns/10ps
`include "thermal_limit_map.svh"
module reg_host #(
    parameter thermal_limit_pkg::temp_t high_limit = 16'sh0370
) (
    // Clock
    input  wire logic       sys_clk,
    // Register port
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic [7:0]      reg_wdata,
    output logic            reg_rd
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end
    // Data is inverted once released so a stale byte can never look valid
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge sys_clk);
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic get(input logic [7:0] a);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge sys_clk);
        reg_rd   = 1'b0;
    endtask
    // Limit bytes hold no reserved bits, so nothing reserved is written as 1
    task automatic put16(input logic [7:0] a, input logic [15:0] v);
        put(a, v[7:0]);
        put(a + 8'h01, v[15:8]);
    endtask
    // Asked values are bent so clo falls below lo and cup above high_limit; lo is not checked against cup
    task automatic set_limits(inout thermal_limit_pkg::temp_t lo, clo, cup);
        if (lo == 16'sh8000) begin
            lo = 16'sh0000;
        end
        if (clo >= lo) begin
            clo = lo - 16'sh0001;
        end
        if (cup <= high_limit) begin
            cup = high_limit + 16'sh0001;
        end
        put16(`TL_ADDR_LOWER_LSB, lo);
        put16(`TL_ADDR_CRIT_LOWER_LSB, clo);
        put16(`TL_ADDR_CRIT_UPPER_LSB, cup);
    endtask
endmodule

// File: bench/tb.sv
/*
 * Self-checking bench for the thermal limit register bank.
 * Assumes the reg_host model drives the register port.
 */
`timescale 1ns/10ps
`include "thermal_limit_map.svh"
module tb;
    typedef struct {
        int          sel;
        logic [15:0] exp;
    } note_t;
    logic                     sys_clk = 1'b0;
    logic                     rst = 1'b1;
    logic                     ce = 1'b1;
    logic                     sense_valid = 1'b0;
    logic [2:0]               ev = 3'h0;
    thermal_limit_pkg::temp_t sense_temp = 16'sh0000;
    logic [7:0]               reg_addr;
    logic                     reg_wr;
    logic [7:0]               reg_wdata;
    logic                     reg_rd;
    logic [7:0]               reg_rdata_q;
    logic                     pend;
    logic                     bl;
    logic                     bcl;
    thermal_limit_pkg::temp_t lo_q;
    thermal_limit_pkg::temp_t cu_q;
    thermal_limit_pkg::temp_t cl_q;
    int                       failures = 0;
    int                       checks_done = 0;
    int                       seed = 65;
    note_t                    notes[$];
    string names[7] = '{"rdata", "pending", "below_lower", "below_crit_lower",
                        "lower", "crit_upper", "crit_lower"};

    always #4 sys_clk = ~sys_clk;

    reg_host host (
        .sys_clk   (sys_clk),
        .reg_addr  (reg_addr),
        .reg_wr    (reg_wr),
        .reg_wdata (reg_wdata),
        .reg_rd    (reg_rd)
    );
    thermal_limit_register_bank uut (
        .sys_clk                    (sys_clk),
        .rst                        (rst),
        .ce                         (ce),
        .reg_addr                   (reg_addr),
        .reg_wr                     (reg_wr),
        .reg_wdata                  (reg_wdata),
        .reg_rd                     (reg_rd),
        .reg_rdata_q                (reg_rdata_q),
        .sense_temp                 (sense_temp),
        .sense_valid                (sense_valid),
        .ibi_raise                  (ev[0]),
        .ibi_done                   (ev[1]),
        .clear_all_events           (ev[2]),
        .pending_interrupt_flag     (pend),
        .below_lower_flag           (bl),
        .below_critical_lower_flag  (bcl),
        .lower_threshold_q          (lo_q),
        .critical_upper_threshold_q (cu_q),
        .critical_lower_threshold_q (cl_q)
    );

    function automatic logic [15:0] seen(int s);
        case (s)
            0: return {8'h00, reg_rdata_q};
            1: return {15'h0000, pend};
            2: return {15'h0000, bl};
            3: return {15'h0000, bcl};
            4: return lo_q;
            5: return cu_q;
            default: return cl_q;
        endcase
    endfunction
    task automatic check(string what, logic [15:0] got, logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic note(input int s, input logic [15:0] v);
        notes.push_back('{s, v});
    endtask
    // Looks just after the falling edge, when notes are in and outputs have settled
    always @(negedge sys_clk) begin
        #1;
        while (notes.size() != 0) begin
            check(names[notes[0].sel], seen(notes[0].sel), notes[0].exp);
            void'(notes.pop_front());
        end
    end
    task automatic pulse(input logic [2:0] e);
        @(negedge sys_clk);
        ev = e;
        @(negedge sys_clk);
        ev = 3'h0;
    endtask
    task automatic sense(input thermal_limit_pkg::temp_t t);
        @(negedge sys_clk);
        sense_temp  = t;
        sense_valid = 1'b1;
        @(negedge sys_clk);
        sense_valid = 1'b0;
        sense_temp  = ~t;
        repeat (2) @(negedge sys_clk);
    endtask

    initial begin
        #400000;
        failures++;
        close_out();
    end

    initial begin
        logic [7:0] addrs [7] = '{8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h30};
        logic [7:0] rstv [7] = '{`TL_RST_LOWER_LSB, `TL_RST_LOWER_MSB, `TL_RST_CRIT_UPPER_LSB,
            `TL_RST_CRIT_UPPER_MSB, `TL_RST_CRIT_LOWER_LSB, `TL_RST_CRIT_LOWER_MSB,
            `TL_RST_DEV_STATUS};
        thermal_limit_pkg::temp_t temps [7] = '{16'sh0032, 16'shffc4, 16'shffce, 16'sh0064,
            16'sh00c8, 16'sh0064, 16'shffc4};
        logic [1:0] flags [7] = '{2'b10, 2'b11, 2'b11, 2'b10, 2'b00, 2'b00, 2'b11};
        thermal_limit_pkg::temp_t lo;
        thermal_limit_pkg::temp_t clo;
        thermal_limit_pkg::temp_t cup;
        logic [47:0] vals;
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        note(4, 16'h0000);
        note(5, 16'h0550);
        note(6, 16'h0000);
        for (int i = 0; i < 7; i++) begin
            host.get(addrs[i]);
            note(0, {8'h00, rstv[i]});
        end
        for (int k = 0; k < 4; k++) begin
            lo  = 16'($random(seed));
            clo = 16'($random(seed));
            cup = 16'($random(seed));
            host.set_limits(lo, clo, cup);
            note(4, lo);
            note(5, cup);
            note(6, clo);
            vals = {clo, cup, lo};
            for (int i = 0; i < 6; i++) begin
                host.get(addrs[i]);
                note(0, {8'h00, vals[8*i +: 8]});
            end
        end
        // Status is read-only and unmapped space reads as zero
        host.put(`TL_ADDR_DEV_STATUS, 8'hff);
        host.get(`TL_ADDR_DEV_STATUS);
        note(0, 16'h0000);
        host.get(8'h21);
        note(0, {8'h00, cup[15:8]});
        host.get(8'h40);
        note(0, 16'h0000);
        pulse(3'h1);
        note(1, 16'h0001);
        host.get(`TL_ADDR_DEV_STATUS);
        note(0, 16'h0080);
        pulse(3'h4);
        note(1, 16'h0000);
        pulse(3'h5);
        note(1, 16'h0001);
        pulse(3'h2);
        note(1, 16'h0000);
        lo  = 16'sh0064;
        clo = 16'shffce;
        cup = 16'sh0600;
        host.set_limits(lo, clo, cup);
        // With the enable low, a write and an interrupt event must both be lost
        ce = 1'b0;
        host.put(`TL_ADDR_LOWER_LSB, 8'haa);
        pulse(3'h1);
        ce = 1'b1;
        note(4, 16'h0064);
        note(1, 16'h0000);
        for (int i = 0; i < 7; i++) begin
            sense(temps[i]);
            note(2, {15'h0000, flags[i][1]});
            note(3, {15'h0000, flags[i][0]});
        end
        pulse(3'h5);
        note(1, 16'h0001);
        pulse(3'h4);
        note(1, 16'h0000);
        note(2, 16'h0000);
        note(3, 16'h0000);
        @(negedge sys_clk);
        close_out();
    end
endmodule
